// ==== hw/sync_init_regs.vh ====
// Constants for the converter start-up and resynchronisation sequencer.
// Assumes a 32-bit Avalon-MM slave whose address is a word index, not a byte offset.
//
// Operation
// - With control word zero bit 5 set, the frame marker syncs the FIFO input pointer.
// - With control word zero bit 4 set, the FIFO output pointer may be resynchronised.
// - Control word nineteen bit 1 selects the common sync source for output pointer and divider.
// - Control word eighteen bit 1 set enables divider sync; clear stops divider realignment.
`ifndef SYNC_INIT_REGS_VH
`define SYNC_INIT_REGS_VH

`define OFS_CTRL_ZERO      4'h0
`define OFS_CTRL_EIGHTEEN  4'h1
`define OFS_CTRL_NINETEEN  4'h2
`define OFS_STATUS         4'h3
`define OFS_ALIGN_COUNT    4'h4

`define BIT_IN_PTR_SYNC    5
`define BIT_OUT_PTR_SYNC   4
`define BIT_DIV_SYNC       1
`define BIT_SRC_SEL        1

`define RST_CTRL_ZERO      8'h00
`define RST_CTRL_EIGHTEEN  8'h00
`define RST_CTRL_NINETEEN  8'h00

`define CLEAR_MIN_NS       25
`define CLK_PERIOD_NS      25
`define CLEAR_MIN_CYC      ((`CLEAR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== hw/rise_detect.v ====
// Rising-edge detector for a sync input.
// Assumes the input is already synchronous to clk.
`timescale 1ns/1ps
module rise_detect (
    input  wire clk,
    input  wire rst_n,
    input  wire level_in,
    output wire rise
);
    reg last_ff;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_ff <= 1'b0;
        end else begin
            last_ff <= level_in;
        end
    end

    assign rise = level_in & ~last_ff;
endmodule

// ==== hw/dac_sync_init_sequencer.v ====
// Device-side sync and transmit gating of a dual-channel converter data path.
// Assumes sync inputs, gate and clear are synchronous to clk; registers over Avalon-MM.
// Control words return to defaults on rst_n and on every completed clear pulse.
// Sync inputs are edge-detected, so a level held high realigns only once.
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "sync_init_regs.vh"
module dac_sync_init_sequencer #(
    parameter PTR_W = 3,
    parameter DIV_W = 2
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [3:0]       avs_address,
    input  wire             avs_read,
    input  wire             avs_write,
    input  wire [31:0]      avs_writedata,
    output reg  [31:0]      avs_readdata,
    output reg              avs_waitrequest,
    input  wire             chip_clear_n,
    input  wire             transmit_gate,
    input  wire             frame_marker_in,
    input  wire             output_strobe_in,
    output reg              data_out_valid,
    output reg  [PTR_W-1:0] in_ptr,
    output reg  [PTR_W-1:0] out_ptr,
    output reg  [DIV_W-1:0] div_phase
);
    // One-hot states; the status word returns this code as it stands
    localparam ST_CLEAR = 3'b001;
    localparam ST_IDLE  = 3'b010;
    localparam ST_RUN   = 3'b100;

    // Clear pulse length in clocks, rounded up from the minimum width
    localparam integer CLR_CYC_I = `CLEAR_MIN_CYC;
    localparam [7:0]   CLR_CYC   = CLR_CYC_I[7:0];

    reg [7:0]  ctrl0_ff;
    reg [7:0]  ctrl18_ff;
    reg [7:0]  ctrl19_ff;
    reg [2:0]  state_ff;
    reg [2:0]  nxt_state;
    reg [7:0]  clr_cnt_ff;
    reg        cleared_ff;
    reg [15:0] align_cnt_ff;
    reg        done_ff;
    reg [31:0] nxt_readdata;

    wire frame_rise;
    wire strobe_rise;
    wire in_sync;
    wire out_sync;
    wire div_sync;
    wire common_src;
    wire bus_req;
    wire wr_commit;
    wire clr_apply;
    wire any_sync;

    rise_detect u_frame (
        .clk      (clk),
        .rst_n    (rst_n),
        .level_in (frame_marker_in),
        .rise     (frame_rise)
    );

    rise_detect u_strobe (
        .clk      (clk),
        .rst_n    (rst_n),
        .level_in (output_strobe_in),
        .rise     (strobe_rise)
    );

    // Bit clear picks the frame marker (single source), set picks the strobe
    assign common_src = ctrl19_ff[`BIT_SRC_SEL] ? strobe_rise : frame_rise;
    assign in_sync  = frame_rise & ctrl0_ff[`BIT_IN_PTR_SYNC];
    assign out_sync = common_src & ctrl0_ff[`BIT_OUT_PTR_SYNC];
    assign div_sync = common_src & ctrl18_ff[`BIT_DIV_SYNC];
    assign bus_req  = (avs_read | avs_write) & avs_waitrequest;
    assign any_sync  = in_sync | out_sync | div_sync;
    assign wr_commit = avs_write & ~avs_waitrequest;
    assign clr_apply = cleared_ff & (state_ff == ST_CLEAR);

    // Clear pin is counted so a glitch shorter than the minimum does not wipe settings
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_cnt_ff <= 8'h00;
            cleared_ff <= 1'b0;
        end else if (!chip_clear_n) begin
            if (clr_cnt_ff != CLR_CYC) begin
                clr_cnt_ff <= clr_cnt_ff + 8'h01;
            end
            cleared_ff <= 1'b0;
        end else begin
            cleared_ff <= (clr_cnt_ff == CLR_CYC);
            clr_cnt_ff <= 8'h00;
        end
    end

    // The gate is honoured only once a clear pulse has completed
    always @* begin
        case (state_ff)
            ST_CLEAR: nxt_state = cleared_ff ? ST_IDLE : ST_CLEAR;
            ST_IDLE:  nxt_state = transmit_gate ? ST_RUN : ST_IDLE;
            ST_RUN:   nxt_state = transmit_gate ? ST_RUN : ST_IDLE;
            default:  nxt_state = ST_CLEAR;
        endcase
        // A clear from any state parks the block until the pulse completes
        if (!chip_clear_n) begin
            nxt_state = ST_CLEAR;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff       <= ST_CLEAR;
            data_out_valid <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            // Valid follows the next state, rising on the same edge as the run state
            data_out_valid <= (nxt_state == ST_RUN);
        end
    end

    // Pointers run freely; a qualified sync event reloads them
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_ptr <= {PTR_W{1'b0}};
        end else if (in_sync) begin
            in_ptr <= {PTR_W{1'b0}};
        end else begin
            in_ptr <= in_ptr + 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ptr <= {PTR_W{1'b0}};
        end else if (out_sync) begin
            out_ptr <= {PTR_W{1'b0}};
        end else begin
            out_ptr <= out_ptr + 1'b1;
        end
    end

    // The divider phase takes the same selected source as the output pointer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_phase <= {DIV_W{1'b0}};
        end else if (div_sync) begin
            div_phase <= {DIV_W{1'b0}};
        end else begin
            div_phase <= div_phase + 1'b1;
        end
    end

    // Counts each cycle with at least one qualified sync event, so software can confirm that alignment happened
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            align_cnt_ff <= 16'h0000;
        end else if (any_sync) begin
            align_cnt_ff <= align_cnt_ff + 16'h0001;
        end
    end

    // Read data come from a mux so the answer edge only has to register them
    always @* begin
        case (avs_address)
            `OFS_CTRL_ZERO:     nxt_readdata = {24'h000000, ctrl0_ff};
            `OFS_CTRL_EIGHTEEN: nxt_readdata = {24'h000000, ctrl18_ff};
            `OFS_CTRL_NINETEEN: nxt_readdata = {24'h000000, ctrl19_ff};
            `OFS_STATUS:        nxt_readdata = {29'h0, state_ff};
            `OFS_ALIGN_COUNT:   nxt_readdata = {16'h0000, align_cnt_ff};
            default:            nxt_readdata = 32'h0000_0000;
        endcase
        // A write answer carries zero, so stale data never looks like a fresh read
        if (avs_write) begin
            nxt_readdata = 32'h0000_0000;
        end
    end

    // Control words: a write commits at the edge at which the master sees the answer,
    // so enables change exactly when the host believes they do; a completed
    // clear pulse restores the defaults and outranks a write in the same cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_ff  <= `RST_CTRL_ZERO;
            ctrl18_ff <= `RST_CTRL_EIGHTEEN;
            ctrl19_ff <= `RST_CTRL_NINETEEN;
        end else if (clr_apply) begin
            ctrl0_ff  <= `RST_CTRL_ZERO;
            ctrl18_ff <= `RST_CTRL_EIGHTEEN;
            ctrl19_ff <= `RST_CTRL_NINETEEN;
        end else if (wr_commit) begin
            case (avs_address)
                `OFS_CTRL_ZERO:     ctrl0_ff  <= avs_writedata[7:0];
                `OFS_CTRL_EIGHTEEN: ctrl18_ff <= avs_writedata[7:0];
                `OFS_CTRL_NINETEEN: ctrl19_ff <= avs_writedata[7:0];
                default:            ctrl0_ff  <= ctrl0_ff;
            endcase
        end
    end

    // Handshake: one wait cycle, answer at the second edge; a completed clear delays the answer by one edge
    // bus_req needs waitrequest high, so a request still held in its answer cycle is not taken twice
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            done_ff         <= 1'b0;
        end else if (clr_apply) begin
            avs_waitrequest <= 1'b1;
            done_ff         <= 1'b0;
        end else if (bus_req && !done_ff) begin
            done_ff         <= 1'b1;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= nxt_readdata;
        end else begin
            avs_waitrequest <= 1'b1;
            done_ff         <= 1'b0;
        end
    end
endmodule

// ==== verification/host_model.sv ====
// Host partner: drives clear, gate and sync pins on bench request.
// Assumes requests are clk-synchronous; each pulse is one cycle.
`timescale 1ns/1ps
module host_model (
    input  logic clk,
    input  logic rst_n,
    input  logic clr_q,
    input  logic frm_q,
    input  logic str_q,
    input  logic gate_q,
    output logic chip_clear_n,
    output logic transmit_gate,
    output logic frame_marker_in,
    output logic output_strobe_in
);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_clear_n <= 1'b1;
            transmit_gate <= 1'b0;
            frame_marker_in <= 1'b0;
            output_strobe_in <= 1'b0;
        end else begin
            chip_clear_n <= !clr_q;
            transmit_gate <= gate_q;
            frame_marker_in <= frm_q;
            output_strobe_in <= str_q;
        end
    end
endmodule

// ==== verification/dac_sync_sva.sv ====
// Port checks; enable bits are tracked from completed bus writes.
// Assumes no sync pulse or bus access during a clear pulse.
`timescale 1ns/1ps
module dac_sync_sva #(
    parameter PTR_W = 3,
    parameter DIV_W = 2
) (
    input logic             clk,
    input logic             rst_n,
    input logic             avs_read,
    input logic             avs_write,
    input logic             avs_waitrequest,
    input logic [3:0]       avs_address,
    input logic [31:0]      avs_writedata,
    input logic             transmit_gate,
    input logic             chip_clear_n,
    input logic             frame_marker_in,
    input logic             output_strobe_in,
    input logic             data_out_valid,
    input logic [PTR_W-1:0] in_ptr,
    input logic [PTR_W-1:0] out_ptr,
    input logic [DIV_W-1:0] div_phase
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic ein_ff, eout_ff, ediv_ff, esel_ff;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            {ein_ff, eout_ff, ediv_ff, esel_ff} <= 4'h0;
        else if (!chip_clear_n)
            {ein_ff, eout_ff, ediv_ff, esel_ff} <= 4'h0;
        else if (avs_write && !avs_waitrequest) begin
            if (avs_address == 4'h0)
                {ein_ff, eout_ff} <= avs_writedata[5:4];
            if (avs_address == 4'h1)
                ediv_ff <= avs_writedata[1];
            if (avs_address == 4'h2)
                esel_ff <= avs_writedata[1];
        end
    end
    sequence s_in_ev;
        $rose(frame_marker_in);
    endsequence
    sequence s_out_ev;
        esel_ff ? $rose(output_strobe_in) : $rose(frame_marker_in);
    endsequence
    a_in_sync: assert property (s_in_ev ##0 ein_ff |=> in_ptr == '0)
        else $error("in_ptr not reloaded");
    a_in_hold: assert property (s_in_ev ##0 !ein_ff |=> in_ptr == $past(in_ptr) + 1'b1)
        else $error("in_ptr realigned");
    a_out_sync: assert property (s_out_ev ##0 eout_ff |=> out_ptr == '0)
        else $error("out_ptr not reloaded");
    a_out_hold: assert property (s_out_ev ##0 !eout_ff |=> out_ptr == $past(out_ptr) + 1'b1)
        else $error("out_ptr realigned");
    a_div_sync: assert property (s_out_ev ##0 ediv_ff |=> div_phase == '0)
        else $error("divider not reloaded");
    a_div_hold: assert property (s_out_ev ##0 !ediv_ff |=> div_phase == $past(div_phase) + 1'b1)
        else $error("divider realigned");
    a_gate_off: assert property (!transmit_gate |=> !data_out_valid)
        else $error("data passed with gate low");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
        else $error("bus request not answered");
endmodule
bind dac_sync_init_sequencer dac_sync_sva #(.PTR_W(PTR_W), .DIV_W(DIV_W)) sva_i (
    .clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .avs_address(avs_address), .avs_writedata(avs_writedata),
    .transmit_gate(transmit_gate), .chip_clear_n(chip_clear_n), .frame_marker_in(frame_marker_in),
    .output_strobe_in(output_strobe_in), .data_out_valid(data_out_valid), .in_ptr(in_ptr),
    .out_ptr(out_ptr), .div_phase(div_phase));

// ==== verification/tb_top.sv ====
// Bench: host model drives the pins, tasks drive the register bus.
// Assumes one 40 MHz clock; pointers advance by one per cycle unless synced.
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, rd, wr, wt, vld, cn, tg, fm, os, clr_q, frm_q, str_q, gate_q;
    logic ein, eout, ediv, esel;
    logic [3:0] adr;
    logic [31:0] wd, rdat, q, d;
    logic [2:0] ip, op;
    logic [1:0] dp;
    int n_errors, n_checks;
    dac_sync_init_sequencer dac_sync_init_sequencer_i (.clk(clk), .rst_n(rst_n),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_readdata(rdat), .avs_waitrequest(wt), .chip_clear_n(cn), .transmit_gate(tg),
        .frame_marker_in(fm), .output_strobe_in(os), .data_out_valid(vld),
        .in_ptr(ip), .out_ptr(op), .div_phase(dp));
    host_model host_model_i (.clk(clk), .rst_n(rst_n), .clr_q(clr_q), .frm_q(frm_q),
        .str_q(str_q), .gate_q(gate_q), .chip_clear_n(cn), .transmit_gate(tg),
        .frame_marker_in(fm), .output_strobe_in(os));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Holds the request until waitrequest is seen low at an edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] v);
        int k;
        @(posedge clk);
        {rd, wr, adr, wd} <= {!w, w, a, v};
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (wt === 1'b0) break;
        end
        q = rdat;
        if (k == 40) n_errors++;
        {rd, wr} <= 2'b00;
    endtask
    task cfg(input logic [3:0] v);
        {ein, eout, ediv, esel} = v;
        bus(1'b1, 4'h0, {26'h0, v[3:2], 4'h0});
        bus(1'b1, 4'h1, {30'h0, v[1], 1'b0});
        bus(1'b1, 4'h2, {30'h0, v[0], 1'b0});
    endtask
    // Snapshot once the selected pulse (marker or strobe) stands high at the pin, compare at the edge that reloads
    task pulse(input logic s);
        logic [2:0] pi, po;
        logic [1:0] pd;
        logic ev;
        ev = (s == esel);
        @(posedge clk);
        frm_q <= !s;
        str_q <= s;
        @(posedge clk);
        {frm_q, str_q} <= 2'b00;
        #1;
        {pi, po, pd} = {ip, op, dp};
        @(posedge clk);
        #1;
        chk("in_ptr", ip, (ein && !s) ? 3'h0 : 3'(pi + 3'h1));
        chk("out_ptr", op, (eout && ev) ? 3'h0 : 3'(po + 3'h1));
        chk("div_phase", dp, (ediv && ev) ? 2'h0 : 2'(pd + 2'h1));
    endtask
    task complete_run;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        complete_run;
    end
    initial begin
        {rst_n, rd, wr, adr, wd, clr_q, frm_q, str_q, gate_q} = '0;
        void'($urandom(80));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 4'(i), 32'h0);
            chk("reset_word", q, (i == 3) ? 32'h1 : 32'h0);
        end
        bus(1'b1, 4'h9, 32'hff);
        bus(1'b0, 4'h9, 32'h0);
        chk("unmapped", q, 32'h0);
        @(posedge clk) clr_q <= 1'b1;
        @(posedge clk) clr_q <= 1'b0;
        repeat (3) @(posedge clk);
        bus(1'b0, 4'h3, 32'h0);
        chk("status", q, 32'h2);
        for (int i = 0; i < 3; i++) begin
            d = $urandom;
            bus(1'b1, 4'(i), d);
            bus(1'b0, 4'(i), 32'h0);
            chk("ctrl_word", q, {24'h0, d[7:0]});
        end
        @(posedge clk) clr_q <= 1'b1;
        @(posedge clk) clr_q <= 1'b0;
        repeat (3) @(posedge clk);
        bus(1'b0, 4'h0, 32'h0);
        chk("cleared_word", q, 32'h0);
        $display("reset and register test done");
        for (int i = 0; i < 16; i++) begin
            cfg(4'(i));
            pulse(1'b0);
            pulse(1'b1);
        end
        $display("sync test done");
        cfg(4'h0);
        @(posedge clk) gate_q <= 1'b1;
        repeat (3) @(posedge clk);
        chk("valid", vld, 32'h1);
        bus(1'b0, 4'h3, 32'h0);
        chk("status", q, 32'h4);
        @(posedge clk) gate_q <= 1'b0;
        repeat (3) @(posedge clk);
        chk("valid", vld, 32'h0);
        $display("gate test done");
        complete_run;
    end
endmodule
